// ==== tb/spsp_partner.sv ====
// external serial peripheral answering the port in master mode
module spsp_partner
(
  // link
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // setup
  input wire logic cpol,
  input wire logic cke,
  input wire logic m16,
  input wire logic load,
  input wire logic [15:0] load_word,
  output logic [15:0] got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sh = 16'h0000;
  logic bit_in = 1'b0;
  assign miso = m16 ? sh[15] : sh[7];
  assign got = sh;
  always @(posedge load)
  begin
    sh = load_word;
  end
  // msb first, shifts on idle-going edge
  // edge select low: capture and shift together there
  always @(sck)
  begin
    if (sck == cpol)
      sh = {sh[14:0], cke ? bit_in : mosi};
    else
      bit_in = mosi;
  end
endmodule

// ==== tb/spsp_port_sva.sv ====
// concurrent checks on the serial port top-level ports
module spsp_port_sva
  import spsp_pkg::*;
(
  // clock and controls
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic port_enable,
  input wire logic master_mode,
  input wire logic output_disable,
  input wire logic transfer_done_irq_en,
  // buffers, status and pins
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic transmit_full,
  input wire logic rx_read,
  input wire logic [15:0] rx_data,
  input wire logic receive_full,
  input wire logic transfer_done_flag,
  input wire logic receive_overflow_flag,
  input wire logic transfer_done_irq,
  input wire logic shift_clock_pin_oe,
  input wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  property p_irq;
    $past(clk_en) |-> transfer_done_irq == (transfer_done_flag && $past(transfer_done_irq_en));
  endproperty
  a_irq: assert property (p_irq) else $error("irq not flag and enable");
  property p_dir;
    port_enable && $past(port_enable) && $stable(master_mode) |-> shift_clock_pin_oe == master_mode;
  endproperty
  a_dir: assert property (p_dir) else $error("clock pin direction wrong");
  property p_dis;
    output_disable && $past(output_disable) |-> !serial_out_oe;
  endproperty
  a_dis: assert property (p_dis) else $error("data out driven while disabled");
  property p_ovf;
    receive_overflow_flag && !rx_read && clk_en |=> $stable(rx_data);
  endproperty
  a_ovf: assert property (p_ovf) else $error("receive data changed in overflow");
  property p_rd;
    rx_read && clk_en |=> !receive_overflow_flag;
  endproperty
  a_rd: assert property (p_rd) else $error("overflow kept after read");
  property p_tx;
    tx_valid && tx_ready && clk_en |=> transmit_full;
  endproperty
  a_tx: assert property (p_tx) else $error("write not flagged full");
  property p_rx;
    $rose(receive_full) |-> transfer_done_flag;
  endproperty
  a_rx: assert property (p_rx) else $error("word stored without done flag");
  property p_full;
    !tx_ready |-> transmit_full;
  endproperty
  a_full: assert property (p_full) else $error("refusing with empty buffer");
  c_ovf: cover property ($rose(receive_overflow_flag));
  c_irq: cover property ($rose(transfer_done_irq));
  c_stall: cover property ($fell(tx_ready));
endmodule

bind spsp_port spsp_port_sva u_sva (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
  .port_enable(port_enable), .master_mode(master_mode), .output_disable(output_disable),
  .transfer_done_irq_en(transfer_done_irq_en), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .transmit_full(transmit_full), .rx_read(rx_read), .rx_data(rx_data),
  .receive_full(receive_full), .transfer_done_flag(transfer_done_flag),
  .receive_overflow_flag(receive_overflow_flag), .transfer_done_irq(transfer_done_irq),
  .shift_clock_pin_oe(shift_clock_pin_oe), .serial_out_oe(serial_out_oe));

// ==== tb/spsp_port_tb_top.sv ====
// self-checking bench for the serial port
module spsp_port_tb_top
  import spsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, reset = 1'b1, port_enable = 1'b0, master_mode = 1'b1, m16 = 1'b1;
  logic cpol = 1'b0, sdi = 1'b0, sck_in = 1'b0, ssn = 1'b1, sce = 1'b0, odis = 1'b0;
  logic sidl = 1'b0, cidle = 1'b0, ien = 1'b0, tx_valid = 1'b0, rx_read = 1'b0, dclr = 1'b0;
  logic load = 1'b0, ces = 1'b1;
  logic [2:0] sec = 3'h3;
  logic [15:0] tx_data = 16'h0000, ld = 16'h0000, d, got, rx_data;
  logic tx_ready, tfull, rfull, done, ovf, irq, sck, sck_oe, miso, sdo, sdo_oe, sin;
  logic [15:0] exp16 [3] = '{16'h5a3c, 16'hc3a5, 16'h0f1e};
  int n_mismatch = 0, samples_checked = 0;
  // slave data comes from the bench, master data from the peripheral model
  assign sin = master_mode ? miso : sdi;
  spsp_port u_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(1'b1), .port_enable(port_enable),
    .master_mode(master_mode), .word_size_16(m16), .clock_polarity(cpol),
    .clock_edge_sel(ces), .select_control_enable(sce), .output_disable(odis),
    .stop_in_idle(sidl), .cpu_idle(cidle), .primary_prescale(2'h0),
    .secondary_prescale(sec), .transfer_done_irq_en(ien), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .transmit_full(tfull), .rx_read(rx_read),
    .rx_data(rx_data), .receive_full(rfull), .done_flag_clear(dclr),
    .transfer_done_flag(done), .receive_overflow_flag(ovf), .transfer_done_irq(irq),
    .shift_clock_pin_in(sck_in), .shift_clock_pin_out(sck), .shift_clock_pin_oe(sck_oe),
    .serial_in_pin(sin), .serial_out_pin(sdo), .serial_out_oe(sdo_oe),
    .slave_select_n(ssn));
  spsp_partner u_part (.sck(sck), .mosi(sdo), .miso(miso), .cpol(cpol), .cke(ces), .m16(m16),
    .load(load), .load_word(ld), .got(got));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // caller lowers valid, so back-to-back writes never toggle it
  // ready is read settled, before the edge that takes the word
  task automatic wr(input logic [15:0] w);
    int n;
    n = 0;
    tx_data = w;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1 && n < 500)
    begin
      n++;
      tick(1);
    end
    chk({15'h0, tx_ready}, 16'h0001);
    tick(1);
  endtask
  task automatic wdone();
    int n;
    n = 0;
    while (done !== 1'b1 && n++ < 3000)
      tick(1);
    chk({15'h0, done}, 16'h0001);
  endtask
  task automatic rd(input logic [15:0] exp, input logic [15:0] mask);
    chk(rx_data & mask, exp);
    rx_read = 1'b1;
    dclr = 1'b1;
    tick(1);
    rx_read = 1'b0;
    dclr = 1'b0;
    chk({14'h0, rfull, ovf}, 16'h0000);
  endtask
  task automatic pl(input logic [15:0] w);
    ld = w;
    load = 1'b1;
    tick(1);
    load = 1'b0;
  endtask
  task automatic sclk(input int n, input logic [15:0] din);
    d = 16'h0000;
    for (int i = 0; i < n; i++)
    begin
      sdi = din[15 - i];
      tick(5);
      d = {d[14:0], sdo};
      sck_in = 1'b1;
      tick(5);
      sck_in = 1'b0;
    end
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #300000;
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    tick(16);
    reset = 1'b0;
    port_enable = 1'b1;
    cidle = 1'b1;
    pl(16'h5a3c);
    wr(16'hc3a5);
    wr(16'h0f1e);
    wr(16'h7788);
    tx_valid = 1'b0;
    chk({15'h0, tx_ready}, 16'h0000);
    foreach (exp16[i])
    begin
      wdone();
      chk({15'h0, irq}, 16'h0000);
      rd(exp16[i], 16'hffff);
    end
    tick(8);
    chk(got, 16'h7788);
    port_enable = 1'b0;
    m16 = 1'b0;
    cpol = 1'b1;
    ces = 1'b0;
    sec = 3'h2;
    ien = 1'b1;
    tick(4);
    port_enable = 1'b1;
    pl(16'h00b4);
    wr(16'h0069);
    tx_valid = 1'b0;
    wdone();
    tick(1);
    chk({15'h0, irq}, 16'h0001);
    dclr = 1'b1;
    wr(16'h00e1);
    tx_valid = 1'b0;
    dclr = 1'b0;
    wdone();
    chk({15'h0, ovf}, 16'h0001);
    tick(8);
    dclr = 1'b1;
    wr(16'h0033);
    tx_valid = 1'b0;
    dclr = 1'b0;
    tick(100);
    chk({13'h0, done, sck, tfull}, 16'h0003);
    sidl = 1'b1;
    rd(16'h00b4, 16'h00ff);
    tick(60);
    chk({14'h0, sck, tfull}, 16'h0003);
    sidl = 1'b0;
    wdone();
    rd(16'h00e1, 16'h00ff);
    tick(8);
    chk(got & 16'h00ff, 16'h0033);
    odis = 1'b1;
    tick(3);
    chk({15'h0, sdo_oe}, 16'h0000);
    odis = 1'b0;
    port_enable = 1'b0;
    master_mode = 1'b0;
    m16 = 1'b1;
    cpol = 1'b0;
    ces = 1'b1;
    sce = 1'b1;
    tick(4);
    port_enable = 1'b1;
    tick(4);
    chk({14'h0, sck_oe, sdo_oe}, 16'h0000);
    ssn = 1'b0;
    sclk(5, 16'hffff);
    ssn = 1'b1;
    tick(6);
    wr(16'ha55a);
    tx_valid = 1'b0;
    ssn = 1'b0;
    sclk(16, 16'h1234);
    chk(d, 16'ha55a);
    wdone();
    rd(16'h1234, 16'hffff);
    report_and_stop();
  end
endmodule

// ==== verilog/spsp_fifo2.sv ====
// two-entry transmit buffer with valid and ready on both sides
module spsp_fifo2
  import spsp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // fill side
  input wire logic [15:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [15:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  // level
  output logic pending
);
  typedef struct packed
  {
    logic [FIFO_DEPTH-1:0][15:0] mem;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic ready;
    logic pend;
  } spsp_fifo_s;

  spsp_fifo_s s_ff;
  spsp_fifo_s nxt_s;
  logic push;
  logic pop;

  always_comb
  begin
    nxt_s = s_ff;
    push = in_valid && s_ff.ready;
    pop = out_ready && (s_ff.count != 2'h0);
    if (push)
    begin
      nxt_s.mem[s_ff.wr_ptr] = in_data;
      nxt_s.wr_ptr = ~s_ff.wr_ptr;
    end
    if (pop)
    begin
      nxt_s.rd_ptr = ~s_ff.rd_ptr;
    end
    nxt_s.count = 2'(s_ff.count + {1'b0, push} - {1'b0, pop});
    // registered so the ready port comes from a flop
    nxt_s.ready = (nxt_s.count != 2'h2);
    nxt_s.pend = (nxt_s.count != 2'h0);
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_ff <= '0;
      s_ff.ready <= 1'b1;
    end
    else if (clk_en)
    begin
      s_ff <= nxt_s;
    end
  end

  assign in_ready = s_ff.ready;
  assign out_valid = s_ff.pend;
  assign out_data = s_ff.mem[s_ff.rd_ptr];
  assign pending = s_ff.pend;
endmodule

// ==== verilog/spsp_pkg.sv ====
// shared constants, types and decode helpers of the serial port
package spsp_pkg;
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam int DIV_W = 10;
  localparam int FIFO_DEPTH = 2;
  localparam logic [4:0] BITS_BYTE = 5'h08;
  localparam logic [4:0] BITS_WORD = 5'h10;
  localparam int CTRL_WORD_SIZE_POS = 10;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [9:0] DIV_ONE = 10'h001;
  localparam logic [2:0] SYNC_RESET = 3'h4;

  typedef enum logic [1:0]
  {
    SPSP_IDLE = 2'b00,
    SPSP_RUN = 2'b01,
    SPSP_TAIL = 2'b11
  } spsp_state_e;

  // half shift clock period in clk_sys cycles
  function automatic logic [9:0] spsp_half_period(input logic [1:0] pri, input logic [2:0] sec);
    logic [9:0] fac;
    logic [9:0] mul;
    fac = DIV_ONE << {pri, 1'b0};
    mul = {7'h00, sec} + DIV_ONE;
    return 10'(fac * mul);
  endfunction

  // bit presented on the data line for the chosen word size
  function automatic logic spsp_msb(input logic [15:0] w, input logic m16);
    return m16 ? w[15] : w[7];
  endfunction
endpackage

// ==== verilog/spsp_port.sv ====
// serial peripheral port: shift engine, receive buffer and status
module spsp_port
  import spsp_pkg::*;
(
  // clock, reset and enable
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // configuration
  input wire logic port_enable,
  input wire logic master_mode,
  input wire logic word_size_16,
  input wire logic clock_polarity,
  input wire logic clock_edge_sel,
  input wire logic select_control_enable,
  input wire logic output_disable,
  input wire logic stop_in_idle,
  input wire logic cpu_idle,
  input wire logic [1:0] primary_prescale,
  input wire logic [2:0] secondary_prescale,
  input wire logic transfer_done_irq_en,
  // data buffer write side
  input wire logic [15:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic transmit_full,
  // data buffer read side
  input wire logic rx_read,
  output logic [15:0] rx_data,
  output logic receive_full,
  // status
  input wire logic done_flag_clear,
  output logic transfer_done_flag,
  output logic receive_overflow_flag,
  output logic transfer_done_irq,
  // pins
  input wire logic shift_clock_pin_in,
  output logic shift_clock_pin_out,
  output logic shift_clock_pin_oe,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  input wire logic slave_select_n
);
  typedef struct packed
  {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic sck_prev;
    spsp_state_e state;
    logic [9:0] div_cnt;
    logic [4:0] bit_cnt;
    logic [15:0] shift;
    logic loaded;
    logic m16_prev;
    logic sck_out;
    logic sck_oe;
    logic sdo;
    logic sdo_oe;
    logic [15:0] rx_buf;
    logic rx_full;
    logic ovf;
    logic done;
    logic irq;
  } spsp_port_s;

  spsp_port_s s_ff;
  spsp_port_s nxt_s;
  logic [15:0] fifo_data;
  logic fifo_valid;
  logic pop;

  // transmit buffer; engine only pops when it may load
  // pending is the transmit full flag
  spsp_fifo2 u_txbuf
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .pending(transmit_full)
  );

  always_comb
  begin
    logic sck_act;
    logic sdi;
    logic ssn;
    logic [4:0] nbits;
    logic [9:0] half;
    logic eng_reset;
    logic lead;
    logic trail;
    logic sample_ev;
    logic output_ev;
    logic complete;
    logic active_now;
    sck_act = 1'b0;
    sdi = 1'b0;
    ssn = 1'b1;
    nbits = BITS_BYTE;
    half = DIV_ONE;
    eng_reset = 1'b0;
    lead = 1'b0;
    trail = 1'b0;
    sample_ev = 1'b0;
    output_ev = 1'b0;
    complete = 1'b0;
    active_now = 1'b0;
    nxt_s = s_ff;
    pop = 1'b0;

    // two-flop synchronisers: sck, sdi, select
    nxt_s.sync1 = {slave_select_n, serial_in_pin, shift_clock_pin_in};
    nxt_s.sync2 = s_ff.sync1;
    sck_act = s_ff.sync2[0] ^ clock_polarity;
    sdi = s_ff.sync2[1];
    ssn = s_ff.sync2[2];
    nbits = word_size_16 ? BITS_WORD : BITS_BYTE;
    half = spsp_half_period(primary_prescale, secondary_prescale);

    if (rx_read)
    begin
      nxt_s.rx_full = 1'b0;
      nxt_s.ovf = 1'b0;
    end
    if (done_flag_clear)
    begin
      nxt_s.done = 1'b0;
    end

    eng_reset = !port_enable || (word_size_16 != s_ff.m16_prev);
    if (!master_mode && select_control_enable && ssn)
    begin
      eng_reset = 1'b1;
    end
    nxt_s.m16_prev = word_size_16;
    nxt_s.sck_prev = sck_act;
    lead = sck_act && !s_ff.sck_prev;
    trail = !sck_act && s_ff.sck_prev;

    if (stop_in_idle && cpu_idle)
    begin
      nxt_s.state = s_ff.state;
    end
    else if (eng_reset)
    begin
      nxt_s.state = SPSP_IDLE;
      nxt_s.div_cnt = 10'h000;
      nxt_s.bit_cnt = 5'h00;
      nxt_s.loaded = 1'b0;
      nxt_s.sck_out = clock_polarity;
    end
    else if (master_mode)
    begin
      case (s_ff.state)
        SPSP_IDLE:
        begin
          nxt_s.sck_out = clock_polarity;
          nxt_s.div_cnt = 10'h000;
          nxt_s.bit_cnt = 5'h00;
          if (fifo_valid && !s_ff.ovf)
          begin
            pop = 1'b1;
            nxt_s.shift = fifo_data;
            nxt_s.sdo = spsp_msb(fifo_data, word_size_16);
            nxt_s.state = SPSP_RUN;
          end
        end
        SPSP_RUN:
        begin
          nxt_s.div_cnt = 10'(s_ff.div_cnt + DIV_ONE);
          if (nxt_s.div_cnt >= half)
          begin
            nxt_s.div_cnt = 10'h000;
            active_now = s_ff.sck_out ^ clock_polarity;
            nxt_s.sck_out = ~s_ff.sck_out;
            sample_ev = active_now ? !clock_edge_sel : clock_edge_sel;
            output_ev = !sample_ev;
            if (sample_ev && (5'(s_ff.bit_cnt + 5'h01) == nbits))
            begin
              nxt_s.state = active_now ? SPSP_IDLE : SPSP_TAIL;
            end
          end
        end
        SPSP_TAIL:
        begin
          nxt_s.div_cnt = 10'(s_ff.div_cnt + DIV_ONE);
          if (nxt_s.div_cnt >= half)
          begin
            nxt_s.div_cnt = 10'h000;
            nxt_s.sck_out = clock_polarity;
            nxt_s.state = SPSP_IDLE;
          end
        end
        default:
        begin
          nxt_s.state = SPSP_IDLE;
        end
      endcase
    end
    else
    begin
      nxt_s.state = SPSP_IDLE;
      nxt_s.sck_out = clock_polarity;
      if (!s_ff.loaded && (s_ff.bit_cnt == 5'h00) && fifo_valid)
      begin
        pop = 1'b1;
        nxt_s.shift = fifo_data;
        nxt_s.sdo = spsp_msb(fifo_data, word_size_16);
        nxt_s.loaded = 1'b1;
      end
      else if (!s_ff.ovf)
      begin
        sample_ev = clock_edge_sel ? lead : trail;
        output_ev = clock_edge_sel ? trail : lead;
      end
    end

    if (sample_ev)
    begin
      nxt_s.shift = {s_ff.shift[14:0], sdi};
      nxt_s.bit_cnt = 5'(s_ff.bit_cnt + 5'h01);
      if (nxt_s.bit_cnt == nbits)
      begin
        complete = 1'b1;
        nxt_s.bit_cnt = 5'h00;
        nxt_s.loaded = 1'b0;
      end
    end
    else if (output_ev)
    begin
      // out of bit 7 or 15
      nxt_s.sdo = spsp_msb(s_ff.shift, word_size_16);
    end

    if (complete)
    begin
      if (nxt_s.rx_full)
      begin
        nxt_s.ovf = 1'b1;
      end
      else
      begin
        nxt_s.rx_buf = nxt_s.shift;
        nxt_s.rx_full = 1'b1;
      end
      nxt_s.done = 1'b1;
    end

    nxt_s.sck_oe = port_enable && master_mode;
    nxt_s.sdo_oe = port_enable && !output_disable;
    if (!master_mode && select_control_enable && ssn)
    begin
      nxt_s.sdo_oe = 1'b0;
    end
    nxt_s.irq = nxt_s.done && transfer_done_irq_en;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_ff <= '0;
      s_ff.sync1 <= SYNC_RESET;
      s_ff.sync2 <= SYNC_RESET;
      s_ff.shift <= RESET_WORD;
      s_ff.rx_buf <= RESET_WORD;
    end
    else if (clk_en)
    begin
      s_ff <= nxt_s;
    end
  end

  assign rx_data = s_ff.rx_buf;
  assign receive_full = s_ff.rx_full;
  assign transfer_done_flag = s_ff.done;
  assign receive_overflow_flag = s_ff.ovf;
  assign transfer_done_irq = s_ff.irq;
  assign shift_clock_pin_out = s_ff.sck_out;
  assign shift_clock_pin_oe = s_ff.sck_oe;
  assign serial_out_pin = s_ff.sdo;
  assign serial_out_oe = s_ff.sdo_oe;
endmodule
